// File: hdl/hppc_top.sv
/*
 * halt state control and peripheral power-disable register, wishbone slave.
 * assumes rst_n is the power-on reset; other resets arrive as sys_reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "hppc_map.svh"
module hppc_top
#(
	parameter int ADDR_W = `HPPC_ADDR_W
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sys_reset,
	input wire logic halt_req,
	input wire logic stop_mode,
	input wire logic irq_pending,
	input wire logic wdt_timeout,
	input wire logic bor_event,
	input wire logic wdt_enable,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	output logic core_run,
	output logic osc_enable,
	output logic sysclk_enable,
	output logic wdt_osc_enable,
	output logic wdt_count_enable,
	output logic periph_clk_enable,
	output logic cmp_enable,
	output logic bod_enable
);
	import hppc_pkg::*;

	// ==========================================
	// parameter check
	// offsets run up to 0x08, so fewer than four address bits cannot decode them
	if (ADDR_W < 4)
	begin : g_addr_narrow
		$error("hppc_top: ADDR_W too small for the register offsets");
	end
	else if (ADDR_W > 32)
	begin : g_addr_wide
		$error("hppc_top: ADDR_W wider than a wishbone address");
	end

	// ==========================================
	// wake sources
	logic any_wake;
	logic [4:0] wake_vec;
	logic por_pulse_q;
	hppc_wake u_wake
	(
		.irq_pending(irq_pending),
		.wdt_timeout(wdt_timeout),
		.por_event(por_pulse_q),
		.bor_event(bor_event),
		.ext_reset(sys_reset),
		.any_wake(any_wake),
		.wake_vec(wake_vec)
	);

	// one cycle after power-on release counts as a power-on wake
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			por_pulse_q <= 1'b1;
		else
			por_pulse_q <= 1'b0;
	end

	// ==========================================
	// halt state
	hppc_state_e state_q;
	hppc_state_e state_d;
	logic [4:0] wake_cause_q;
	// a wake in the same cycle wins, so a halt can never swallow it
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			HPPC_RUN:
				if (halt_req && !any_wake)
					state_d = HPPC_HALT;
			HPPC_HALT:
				if (any_wake)
					state_d = HPPC_RUN;
			default:
				state_d = HPPC_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= HPPC_RUN;
		else
			state_q <= state_d;
	end

	// last wake cause, kept for software
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			wake_cause_q <= 5'h00;
		else if (state_q == HPPC_HALT && any_wake)
			wake_cause_q <= wake_vec;
	end

	// ==========================================
	// registers
	hppc_byte_t pwr_q;
	logic ao_q;
	logic acc;
	logic hit_pwr;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_any;

	// one compare shared by every register decode
	function automatic logic addr_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] ofs);
		return adr == ADDR_W'(ofs);
	endfunction

	// gating on ack and err keeps every answer one cycle long
	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign hit_pwr = addr_hit(wb_adr_i, `HPPC_OFS_PWR);
	assign hit_ctrl = addr_hit(wb_adr_i, `HPPC_OFS_CTRL);
	assign hit_stat = addr_hit(wb_adr_i, `HPPC_OFS_STAT);
	assign hit_any = hit_pwr || hit_ctrl || hit_stat;

	// only rst_n resets it; sys_reset is deliberately ignored here
	// reserved bits are stored as written; software owns their values
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pwr_q <= `HPPC_PWR_RESET;
		else if (acc && wb_we_i && hit_pwr && wb_sel_i[0])
			pwr_q <= wb_dat_i[7:0];
	end

	// always-on option, held like a flash option: survives system reset
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ao_q <= 1'b0;
		else if (acc && wb_we_i && hit_ctrl && wb_sel_i[0])
			ao_q <= wb_dat_i[`HPPC_CTRL_AO_BIT];
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			// unmapped offsets answer with err and read back zero
			wb_ack_o <= acc && hit_any;
			wb_err_o <= acc && !hit_any;
			if (acc && hit_pwr)
				wb_dat_o <= {24'h00_0000, pwr_q};
			else if (acc && hit_ctrl)
				wb_dat_o <= {31'h0000_0000, ao_q};
			else if (acc && hit_stat)
				wb_dat_o <= {26'h000_0000, wake_cause_q, state_q == HPPC_HALT};
			else
				wb_dat_o <= 32'h0000_0000;
		end
	end

	// ==========================================
	// clock and power enables
	// core_run is built from state_d so it drops on the very edge that takes the halt
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_run <= 1'b0;
			osc_enable <= 1'b1;
			sysclk_enable <= 1'b1;
			wdt_osc_enable <= 1'b1;
			wdt_count_enable <= 1'b0;
			periph_clk_enable <= 1'b1;
			cmp_enable <= 1'b1;
			bod_enable <= 1'b1;
		end
		else
		begin
			core_run <= state_d == HPPC_RUN;
			osc_enable <= 1'b1;
			sysclk_enable <= 1'b1;
			wdt_osc_enable <= 1'b1;
			wdt_count_enable <= wdt_enable;
			periph_clk_enable <= 1'b1;
			cmp_enable <= !pwr_q[`HPPC_PWR_CMP_BIT];
			// always-on option overrides both the disable bit and stop
			bod_enable <= ao_q || !(pwr_q[`HPPC_PWR_BOD_BIT] || stop_mode);
		end
	end
endmodule
`default_nettype wire

// File: hdl/hppc_wake.sv
/*
 * wake source combiner for the halt state machine.
 * assumes all wake inputs are synchronous, active-high levels or pulses.
 */
`timescale 1ns/1ps
`default_nettype none
module hppc_wake
(
	input wire logic irq_pending,
	input wire logic wdt_timeout,
	input wire logic por_event,
	input wire logic bor_event,
	input wire logic ext_reset,
	output logic any_wake,
	output logic [4:0] wake_vec
);
	always_comb
	begin
		wake_vec = {ext_reset, bor_event, por_event, wdt_timeout, irq_pending};
		any_wake = |wake_vec;
	end
endmodule
`default_nettype wire

// File: shared/hppc_map.svh
/*
 * register map, field positions, reset values for the halt and
 * peripheral power control block. assumes an 8-bit wishbone byte address.
 */
`ifndef HPPC_MAP_SVH
`define HPPC_MAP_SVH
`define HPPC_ADDR_W 8
`define HPPC_OFS_PWR 8'h00
`define HPPC_OFS_CTRL 8'h04
`define HPPC_OFS_STAT 8'h08
`define HPPC_PWR_RESET 8'h88
`define HPPC_PWR_BOD_BIT 4
`define HPPC_PWR_CMP_BIT 1
`define HPPC_CTRL_AO_BIT 0
`define HPPC_STAT_HALT_BIT 0
`define HPPC_STAT_WAKE_LSB 1
`endif

// File: shared/hppc_pkg.sv
/*
 * types for the halt and peripheral power control block.
 * assumes hppc_map.svh is on the include path.
 */
package hppc_pkg;
	typedef enum logic [0:0] {
		HPPC_RUN = 1'b0,
		HPPC_HALT = 1'b1
	} hppc_state_e;
	typedef logic [7:0] hppc_byte_t;
endpackage

// File: tb/hppc_top_properties.sv
/* port checker for hppc_top.
 assumes binding to hppc_top, rst_n the power-on reset. */
`timescale 1ns/1ps
`default_nettype none
module hppc_props
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sys_reset,
	input wire logic halt_req,
	input wire logic irq_pending,
	input wire logic wdt_timeout,
	input wire logic bor_event,
	input wire logic wdt_enable,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic core_run,
	input wire logic osc_enable,
	input wire logic sysclk_enable,
	input wire logic wdt_osc_enable,
	input wire logic wdt_count_enable,
	input wire logic periph_clk_enable,
	input wire logic cmp_enable,
	input wire logic bod_enable
);
logic wk;
assign wk = irq_pending | wdt_timeout | bor_event | sys_reset;
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_n);
chk_halt_entry: assert property ($past(rst_n) && halt_req && !wk |=> !core_run)
	else $error("halt not entered");
chk_clock_kept: assert property (osc_enable && sysclk_enable)
	else $error("clock stopped");
chk_core_hold: assert property ($past(rst_n) && !core_run && !wk |=> !core_run)
	else $error("core left halt");
chk_wdt_kept: assert property ($past(rst_n) |-> wdt_osc_enable && wdt_count_enable == $past(wdt_enable))
	else $error("watchdog stopped");
chk_periph_kept: assert property (periph_clk_enable)
	else $error("peripheral clock off");
chk_wake_exit: assert property (!core_run && wk |=> core_run)
	else $error("no wake");
chk_cmp_follow: assert property (wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0] |-> ##[1:2] cmp_enable == !wb_dat_i[1])
	else $error("comparator enable wrong");
chk_reset_state: assert property ($rose(rst_n) |-> cmp_enable && bod_enable && !core_run)
	else $error("reset outputs wrong");
endmodule
bind hppc_top hppc_props i_props(.*);
`default_nettype wire

// File: tb/hppc_top_test.sv
/* bench for hppc_top.
 assumes the design files and the checker are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module hppc_top_test;
logic ref_clk=0, rst_n=0, sys_reset=0, halt_req=0, stop_mode=0, irq_pending=0, wdt_timeout=0;
logic bor_event=0, wdt_enable=1, wb_cyc_i=0, wb_stb_i=0, wb_we_i=0, wb_ack_o, wb_err_o, core_run;
logic osc_enable, sysclk_enable, wdt_osc_enable, wdt_count_enable, periph_clk_enable;
logic cmp_enable, bod_enable, er;
logic [7:0] wb_adr_i=0;
logic [3:0] wb_sel_i=0, sel=4'hf;
logic [4:0] keep_on;
logic [31:0] wb_dat_i=0, wb_dat_o, rd;
int n_errors=0, comparisons=0;
always #5 ref_clk = ~ref_clk;
hppc_top i_dut(.*);
assign keep_on = {osc_enable, sysclk_enable, wdt_osc_enable, periph_clk_enable, wdt_count_enable};
// ==========
// tasks
task close_out;
	if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
endtask
task chk(input logic [31:0] s, input logic [31:0] e, input string n);
	comparisons++;
	if (s !== e)
	begin
		n_errors++;
		$display("CHECK FAILED %s exp %h got %h", n, e, s);
	end
endtask
task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
	int k;
	{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, sel, d};
	k = 0;
	do
	begin
		@(posedge ref_clk);
		k++;
	end
	while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
	rd = wb_dat_o;
	er = wb_err_o;
	if (k == 20)
	begin
		n_errors++;
		close_out();
	end
	{wb_cyc_i, wb_stb_i} <= 2'b00;
	@(posedge ref_clk);
endtask
// ==========
// sequence
initial
begin
	repeat (6) @(posedge ref_clk);
	rst_n <= 1;
	@(posedge ref_clk);
	bus(0, 8'h00, 0); chk(rd, 32'h88, "pwr reset");
	bus(1, 8'h00, 32'h12); bus(0, 8'h00, 0); chk(rd, 32'h12, "pwr");
	chk({cmp_enable, bod_enable}, 2'b00, "disables");
	bus(1, 8'h04, 1); @(posedge ref_clk); chk(bod_enable, 1, "always on");
	bus(1, 8'h04, 0); bus(1, 8'h00, 2); stop_mode <= 1;
	repeat (2) @(posedge ref_clk); chk(bod_enable, 0, "stop");
	stop_mode <= 0;
	bus(1, 8'h0c, 5); chk(er, 1, "unmapped");
	{halt_req, irq_pending} <= 2'b11;
	repeat (2) @(posedge ref_clk); chk(core_run, 1, "refused halt");
	for (int i = 0; i < 4; i++)
	begin
		{halt_req, irq_pending} <= 2'b10;
		@(posedge ref_clk);
		halt_req <= 0;
		bus(0, 8'h08, 0); chk({rd[0], core_run}, 2'b10, "halted");
		wdt_enable <= i[0];
		repeat (2) @(posedge ref_clk);
		chk(keep_on, {4'hf, i[0]}, "halt clocks");
		{sys_reset, bor_event, wdt_timeout, irq_pending} <= 4'h1 << i;
		repeat (2) @(posedge ref_clk);
		{sys_reset, bor_event, wdt_timeout, irq_pending} <= 4'h0;
		bus(0, 8'h08, 0); chk({rd[5:0], core_run}, {5'h1 << (i + i / 2), 2'b01}, "wake");
	end
	sel = 4'he;
	bus(1, 8'h00, 32'hff);
	sel = 4'hf;
	bus(0, 8'h00, 0); chk(rd, 32'h02, "pwr kept");
	bus(1, 8'h00, 32'h80); chk({cmp_enable, bod_enable}, 2'b11, "enables");
	rst_n <= 0;
	repeat (2) @(posedge ref_clk);
	rst_n <= 1;
	@(posedge ref_clk);
	bus(0, 8'h00, 0); chk(rd, 32'h88, "pwr por");
	chk(core_run, 1, "por run");
	close_out();
end
endmodule
`default_nettype wire
